// ===== hw/mbac_defs.svh
// Constant offsets, memory map and reset values of the mode based access control unit.
`ifndef MBAC_DEFS_SVH
`define MBAC_DEFS_SVH
// -----------------------------------------------------------------
// CPU mode encodings.
// -----------------------------------------------------------------
`define MBAC_MODE_BOOT 3'h0
`define MBAC_MODE_TEST 3'h1
`define MBAC_MODE_OS 3'h2
`define MBAC_MODE_SYS 3'h3
`define MBAC_MODE_USER 3'h4
// -----------------------------------------------------------------
// Physical memory map, inclusive bounds.
// -----------------------------------------------------------------
`define MBAC_TROM_LO 16'h0000
`define MBAC_AROM_LO 16'h1000
`define MBAC_ACM_LO 16'h3FC0
`define MBAC_OEEP_LO 16'h4000
`define MBAC_AEEP_LO 16'h5000
`define MBAC_SROW_LO 16'hBFC0
`define MBAC_ORAM_LO 16'hC000
`define MBAC_ARAM_LO 16'hC800
`define MBAC_PRAM_LO 16'hF000
// -----------------------------------------------------------------
// Special function register groups, selected by address bits [7:4].
// -----------------------------------------------------------------
`define MBAC_GRP_CPU 4'h8
`define MBAC_GRP_SEG 4'h9
`define MBAC_GRP_SYS 4'hA
`define MBAC_GRP_FW 4'hB
`define MBAC_GRP_OS 4'hC
`define MBAC_GRP_TST 4'hD
`define MBAC_PROG_STAT_HI_ADDR 8'hA0
// -----------------------------------------------------------------
// Own register offsets.
// -----------------------------------------------------------------
`define MBAC_SEG_IDX 8'h90
`define MBAC_SEG_RIGHTS 8'h91
`define MBAC_SEG_FIRST_L 8'h92
`define MBAC_SEG_LAST_L 8'h94
`define MBAC_SEG_RELOC_L 8'h96
`define MBAC_SEG_HWM_L 8'h98
`define MBAC_SEG_COMMIT 8'h9A
`define MBAC_FW_CTRL_L 8'hB0
`define MBAC_XWIN_BASE_L 8'hB2
`define MBAC_XWIN_SIZE_L 8'hB4
// -----------------------------------------------------------------
// Reset values.
// -----------------------------------------------------------------
`define MBAC_RST_BYTE 8'h00
`define MBAC_RST_WORD 16'h0000
`endif

// ===== hw/mbac_pkg.sv
// Types shared by the mode based access control unit and its bench.
package mbac_pkg;
  // Kind of memory operation.
  typedef enum logic [1:0] {
    MBAC_OP_READ = 2'b00,
    MBAC_OP_WRITE = 2'b01,
    MBAC_OP_EXEC = 2'b10
  } mbac_op_e;
  // Physical region of an address.
  typedef enum logic [2:0] {
    MBAC_R_TROM = 3'b000,
    MBAC_R_AROM = 3'b001,
    MBAC_R_OEEP = 3'b010,
    MBAC_R_AEEP = 3'b011,
    MBAC_R_ORAM = 3'b100,
    MBAC_R_ARAM = 3'b101,
    MBAC_R_PRAM = 3'b110
  } mbac_region_e;
  // CPU memory request.
  typedef struct packed {
    logic valid;
    mbac_op_e op;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mbac_req_s;
  // Command towards the physical memories.
  typedef struct packed {
    logic en;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mbac_mem_s;
  // One segment table entry; rights are read, write, execute.
  typedef struct packed {
    logic [2:0] rights;
    logic [15:0] first;
    logic [15:0] last;
    logic [15:0] reloc;
    logic [15:0] hwmask;
  } mbac_seg_s;
endpackage

// ===== hw/mbac_top.sv
// Mode based memory and special function register access control unit.
//
// Added by the designer: strobed register access and the placing of the registers.
`include "mbac_defs.svh"
module mbac_top
  import mbac_pkg::*;
#(
  parameter int SEGS = 64
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Current CPU mode.
  input wire logic [2:0] cpu_mode_i,
  // CPU memory request and the command to the memories.
  input wire mbac_req_s cpu_req_i,
  output mbac_mem_s mem_cmd_o,
  output logic violation_o,
  // Coprocessor memory request.
  input wire logic pkc_valid_i,
  input wire logic pkc_write_i,
  input wire logic [15:0] pkc_addr_i,
  input wire logic [7:0] pkc_wdata_i,
  output logic pkc_ready_o,
  output logic pkc_denied_o,
  // Special function register port from the CPU.
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  // Registers held outside this unit.
  output logic [7:0] ext_addr_o,
  output logic [7:0] ext_wdata_o,
  output logic ext_wr_o,
  output logic ext_rd_o,
  input wire logic [7:0] ext_rdata_i
);
  // -----------------------------------------------------------------
  // Storage.
  // -----------------------------------------------------------------
  mbac_seg_s seg_tab_q [SEGS];
  logic [SEGS-1:0] seg_on_q;
  mbac_seg_s stage_q;
  logic [5:0] seg_idx_q;
  logic [15:0] fw_ctrl_q, xwin_base_q, xwin_size_q;
  logic [5:0] cur_seg_q;
  logic cur_ok_q;
  logic rd_ok_q, rd_own_q;
  logic [7:0] own_q;

  // -----------------------------------------------------------------
  // Segment lookup.
  // -----------------------------------------------------------------
  logic [SEGS-1:0] hit;
  logic any_hit;
  logic [5:0] hit_idx;
  // Entries without rights never match, so they act as disabled.
  for (genvar g = 0; g < SEGS; g++) begin : g_hit
    assign hit[g] = seg_on_q[g] && (seg_tab_q[g].rights != 3'b000) &&
                    (cpu_req_i.addr >= seg_tab_q[g].first) &&
                    (cpu_req_i.addr <= seg_tab_q[g].last);
  end

  // The lowest numbered matching segment wins when entries overlap.
  always_comb begin
    any_hit = 1'b0;
    hit_idx = 6'h00;
    for (int i = SEGS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        hit_idx = 6'(i);
      end
    end
  end

  // Map a physical address to its region.
  function automatic mbac_region_e region_of(input logic [15:0] a);
    if (a < `MBAC_AROM_LO) return MBAC_R_TROM;
    if (a < `MBAC_OEEP_LO) return MBAC_R_AROM;
    if (a < `MBAC_AEEP_LO) return MBAC_R_OEEP;
    if (a < `MBAC_ORAM_LO) return MBAC_R_AEEP;
    if (a < `MBAC_ARAM_LO) return MBAC_R_ORAM;
    if (a < `MBAC_PRAM_LO) return MBAC_R_ARAM;
    return MBAC_R_PRAM;
  endfunction

  // -----------------------------------------------------------------
  // Memory rights.
  // -----------------------------------------------------------------
  logic [15:0] phys;
  mbac_region_e reg_c;
  logic is_rd, is_wr, is_ex, mem_ok, in_xwin;
  logic [15:0] xoff;
  // Privileged modes see physical addresses directly; user mode relocates.
  always_comb begin
    mbac_seg_s s;
    s = seg_tab_q[hit_idx];
    phys = cpu_req_i.addr;
    if (cpu_mode_i == `MBAC_MODE_USER) begin
      phys = cpu_req_i.addr + s.reloc;
    end
    reg_c = region_of(phys);
    is_rd = cpu_req_i.op == MBAC_OP_READ;
    is_wr = cpu_req_i.op == MBAC_OP_WRITE;
    is_ex = cpu_req_i.op == MBAC_OP_EXEC;
    xoff = phys - xwin_base_q;
    in_xwin = (reg_c == MBAC_R_ARAM) && (phys >= xwin_base_q) && (xoff < xwin_size_q);
    mem_ok = 1'b0;
    case (cpu_mode_i)
      `MBAC_MODE_BOOT, `MBAC_MODE_OS: begin
        // Boot and OS share one partition; RAM is never executable.
        mem_ok = ((reg_c == MBAC_R_TROM) && !is_wr) ||
                 (reg_c == MBAC_R_OEEP) ||
                 ((reg_c == MBAC_R_ORAM) && !is_ex) ||
                 (is_rd && (phys >= `MBAC_SROW_LO) && (reg_c == MBAC_R_AEEP));
        if (cpu_mode_i == `MBAC_MODE_OS) begin
          mem_ok = mem_ok || (is_rd && (reg_c == MBAC_R_AROM) &&
                   (phys >= `MBAC_ACM_LO)) || (in_xwin && !is_ex);
        end
      end
      `MBAC_MODE_TEST: begin
        mem_ok = (reg_c <= MBAC_R_AROM) ? !is_wr :
                 ((reg_c <= MBAC_R_AEEP) ? 1'b1 : !is_ex);
      end
      `MBAC_MODE_SYS: begin
        mem_ok = ((reg_c == MBAC_R_AROM) && !is_wr) ||
                 (reg_c == MBAC_R_AEEP) || ((reg_c == MBAC_R_ARAM) && !is_ex);
      end
      `MBAC_MODE_USER: begin
        // Segment rights, restricted to what the application area allows.
        mem_ok = any_hit && ((is_rd && s.rights[2]) || (is_wr && s.rights[1]) ||
                 (is_ex && s.rights[0])) &&
                 (((reg_c == MBAC_R_AROM) && !is_wr) || (reg_c == MBAC_R_AEEP) ||
                 ((reg_c == MBAC_R_ARAM) && !is_ex));
      end
      default: mem_ok = 1'b0;
    endcase
  end

  // Coprocessor rights; it only runs when the CPU leaves the memories free.
  logic pkc_ok;
  mbac_region_e pkc_reg;
  always_comb begin
    pkc_reg = region_of(pkc_addr_i);
    pkc_ok = (pkc_reg == MBAC_R_PRAM) ||
             (!pkc_write_i && ((pkc_reg == MBAC_R_OEEP) || (pkc_reg == MBAC_R_AEEP)));
  end
  assign pkc_ready_o = !cpu_req_i.valid;

  // Memory command is registered; a refused access never enables a memory.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mem_cmd_o <= '0;
      violation_o <= 1'b0;
      pkc_denied_o <= 1'b0;
    end else if (cpu_req_i.valid) begin
      mem_cmd_o.en <= mem_ok;
      mem_cmd_o.we <= mem_ok && is_wr;
      mem_cmd_o.addr <= phys;
      mem_cmd_o.wdata <= cpu_req_i.wdata;
      violation_o <= !mem_ok;
      pkc_denied_o <= 1'b0;
    end else begin
      mem_cmd_o.en <= pkc_valid_i && pkc_ok;
      mem_cmd_o.we <= pkc_valid_i && pkc_ok && pkc_write_i;
      mem_cmd_o.addr <= pkc_addr_i;
      mem_cmd_o.wdata <= pkc_wdata_i;
      violation_o <= 1'b0;
      pkc_denied_o <= pkc_valid_i && !pkc_ok;
    end
  end

  // Track the segment of the last allowed user fetch for register rights.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cur_seg_q <= 6'h00;
      cur_ok_q <= 1'b0;
    end else if (cpu_req_i.valid && is_ex && mem_ok && (cpu_mode_i == `MBAC_MODE_USER)) begin
      cur_seg_q <= hit_idx;
      cur_ok_q <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Register access rights.
  // -----------------------------------------------------------------
  logic [3:0] grp;
  logic hw_grp, hw_fw, hw_seg, rd_ok, wr_ok;
  logic [15:0] cur_mask;
  always_comb begin
    grp = sfr_addr_i[7:4];
    hw_grp = sfr_addr_i[7:5] == 3'b111;
    hw_fw = fw_ctrl_q[sfr_addr_i[4:1]];
    cur_mask = seg_tab_q[cur_seg_q].hwmask;
    hw_seg = cur_ok_q && cur_mask[sfr_addr_i[4:1]];
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    if (grp == `MBAC_GRP_CPU) begin
      rd_ok = 1'b1;
      wr_ok = 1'b1;
    end else if (grp == `MBAC_GRP_SEG) begin
      rd_ok = cpu_mode_i == `MBAC_MODE_SYS;
      wr_ok = rd_ok;
    end else begin
      case (cpu_mode_i)
        `MBAC_MODE_BOOT, `MBAC_MODE_TEST: begin
          rd_ok = 1'b1;
          wr_ok = 1'b1;
        end
        `MBAC_MODE_OS: begin
          rd_ok = (grp == `MBAC_GRP_FW) || (grp == `MBAC_GRP_OS) ||
                  (hw_grp && hw_fw) || (sfr_addr_i == `MBAC_PROG_STAT_HI_ADDR);
          wr_ok = (grp == `MBAC_GRP_OS) || (hw_grp && hw_fw);
        end
        `MBAC_MODE_SYS: begin
          rd_ok = (grp == `MBAC_GRP_SYS) || (grp == `MBAC_GRP_FW) || hw_grp;
          wr_ok = rd_ok;
        end
        `MBAC_MODE_USER: begin
          rd_ok = (hw_grp && hw_seg) || (sfr_addr_i == `MBAC_PROG_STAT_HI_ADDR);
          wr_ok = hw_grp && hw_seg;
        end
        default: begin
          rd_ok = 1'b0;
          wr_ok = 1'b0;
        end
      endcase
    end
  end

  // Own registers live in the segmentation and firewall groups.
  logic own_sel;
  assign own_sel = (grp == `MBAC_GRP_SEG) || (grp == `MBAC_GRP_FW);

  // Outside registers see only strobes that passed the check.
  assign ext_addr_o = sfr_addr_i;
  assign ext_wdata_o = sfr_wdata_i;
  assign ext_wr_o = sfr_wr_i && wr_ok && !own_sel;
  assign ext_rd_o = sfr_rd_i && rd_ok && !own_sel;

  // -----------------------------------------------------------------
  // Own register writes.
  // -----------------------------------------------------------------
  logic own_wr;
  assign own_wr = sfr_wr_i && wr_ok && own_sel;

  // Staged entry and pointer; a commit copies the stage into the table.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      seg_idx_q <= 6'h00;
      stage_q <= '0;
      seg_on_q <= '0;
    end else if (own_wr) begin
      case (sfr_addr_i)
        `MBAC_SEG_IDX: seg_idx_q <= sfr_wdata_i[5:0];
        `MBAC_SEG_RIGHTS: stage_q.rights <= sfr_wdata_i[2:0];
        `MBAC_SEG_FIRST_L: stage_q.first[7:0] <= sfr_wdata_i;
        `MBAC_SEG_FIRST_L + 8'h01: stage_q.first[15:8] <= sfr_wdata_i;
        `MBAC_SEG_LAST_L: stage_q.last[7:0] <= sfr_wdata_i;
        `MBAC_SEG_LAST_L + 8'h01: stage_q.last[15:8] <= sfr_wdata_i;
        `MBAC_SEG_RELOC_L: stage_q.reloc[7:0] <= sfr_wdata_i;
        `MBAC_SEG_RELOC_L + 8'h01: stage_q.reloc[15:8] <= sfr_wdata_i;
        `MBAC_SEG_HWM_L: stage_q.hwmask[7:0] <= sfr_wdata_i;
        `MBAC_SEG_HWM_L + 8'h01: stage_q.hwmask[15:8] <= sfr_wdata_i;
        `MBAC_SEG_COMMIT: seg_on_q[seg_idx_q] <= 1'b1;
        default: seg_idx_q <= seg_idx_q;
      endcase
    end
  end

  // Table contents need no reset: the enable vector hides stale entries.
  always_ff @(posedge clock_i) begin
    if (own_wr && (sfr_addr_i == `MBAC_SEG_COMMIT)) begin
      seg_tab_q[seg_idx_q] <= stage_q;
    end
  end

  // Firewall control and exchange window registers.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fw_ctrl_q <= `MBAC_RST_WORD;
      xwin_base_q <= `MBAC_RST_WORD;
      xwin_size_q <= `MBAC_RST_WORD;
    end else if (own_wr) begin
      case (sfr_addr_i)
        `MBAC_FW_CTRL_L: fw_ctrl_q[7:0] <= sfr_wdata_i;
        `MBAC_FW_CTRL_L + 8'h01: fw_ctrl_q[15:8] <= sfr_wdata_i;
        `MBAC_XWIN_BASE_L: xwin_base_q[7:0] <= sfr_wdata_i;
        `MBAC_XWIN_BASE_L + 8'h01: xwin_base_q[15:8] <= sfr_wdata_i;
        `MBAC_XWIN_SIZE_L: xwin_size_q[7:0] <= sfr_wdata_i;
        `MBAC_XWIN_SIZE_L + 8'h01: xwin_size_q[15:8] <= sfr_wdata_i;
        default: fw_ctrl_q <= fw_ctrl_q;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Register reads.
  // -----------------------------------------------------------------
  logic [7:0] own_c;
  always_comb begin
    case (sfr_addr_i)
      `MBAC_SEG_IDX: own_c = {2'b00, seg_idx_q};
      `MBAC_SEG_RIGHTS: own_c = {5'h00, stage_q.rights};
      `MBAC_SEG_FIRST_L: own_c = stage_q.first[7:0];
      `MBAC_SEG_FIRST_L + 8'h01: own_c = stage_q.first[15:8];
      `MBAC_SEG_LAST_L: own_c = stage_q.last[7:0];
      `MBAC_SEG_LAST_L + 8'h01: own_c = stage_q.last[15:8];
      `MBAC_SEG_RELOC_L: own_c = stage_q.reloc[7:0];
      `MBAC_SEG_RELOC_L + 8'h01: own_c = stage_q.reloc[15:8];
      `MBAC_SEG_HWM_L: own_c = stage_q.hwmask[7:0];
      `MBAC_SEG_HWM_L + 8'h01: own_c = stage_q.hwmask[15:8];
      `MBAC_FW_CTRL_L: own_c = fw_ctrl_q[7:0];
      `MBAC_FW_CTRL_L + 8'h01: own_c = fw_ctrl_q[15:8];
      `MBAC_XWIN_BASE_L: own_c = xwin_base_q[7:0];
      `MBAC_XWIN_BASE_L + 8'h01: own_c = xwin_base_q[15:8];
      `MBAC_XWIN_SIZE_L: own_c = xwin_size_q[7:0];
      `MBAC_XWIN_SIZE_L + 8'h01: own_c = xwin_size_q[15:8];
      default: own_c = 8'h00;
    endcase
  end

  // Read answer one cycle after the strobe; a denied read shows zero.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_ok_q <= 1'b0;
      rd_own_q <= 1'b0;
      own_q <= `MBAC_RST_BYTE;
    end else begin
      rd_ok_q <= sfr_rd_i && rd_ok;
      rd_own_q <= own_sel;
      own_q <= own_c;
    end
  end

  // Outside data are registered by their owner, so this is a mux of flops.
  assign sfr_rdata_o = !rd_ok_q ? 8'h00 : (rd_own_q ? own_q : ext_rdata_i);
endmodule

// ===== test/mbac_top_sva.sv
// Port level assertions for the mode based access control unit.
`include "mbac_defs.svh"
module mbac_chk
  import mbac_pkg::*;
(
  // Clock, reset and mode.
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [2:0] cpu_mode_i,
  // Memory side.
  input wire mbac_req_s cpu_req_i,
  input wire mbac_mem_s mem_cmd_o,
  input wire logic violation_o,
  input wire logic pkc_valid_i,
  input wire logic pkc_write_i,
  input wire logic [15:0] pkc_addr_i,
  input wire logic pkc_ready_o,
  input wire logic pkc_denied_o,
  // Register side.
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [7:0] ext_addr_o,
  input wire logic ext_wr_o,
  input wire logic ext_rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------------------------
  // Checks.
  // -----------------------------------------------------------------
  // All checks share the one clock, so reset is given once here.
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_viol_quiet;
    violation_o |-> !mem_cmd_o.en && !mem_cmd_o.we;
  endproperty
  a_viol_quiet: assert property (p_viol_quiet) else $error("refused access reached memory");
  property p_test_read;
    cpu_req_i.valid && cpu_mode_i == `MBAC_MODE_TEST && cpu_req_i.op == MBAC_OP_READ
      |=> mem_cmd_o.en && !violation_o && mem_cmd_o.addr == $past(cpu_req_i.addr);
  endproperty
  a_test_read: assert property (p_test_read) else $error("test mode read not passed");
  property p_sys_trom;
    cpu_req_i.valid && cpu_mode_i == `MBAC_MODE_SYS && cpu_req_i.addr < `MBAC_AROM_LO
      |=> violation_o && !mem_cmd_o.en;
  endproperty
  a_sys_trom: assert property (p_sys_trom) else $error("system mode reached test rom");
  property p_boot_aram;
    cpu_req_i.valid && cpu_mode_i == `MBAC_MODE_BOOT && cpu_req_i.addr >= `MBAC_ARAM_LO
      && cpu_req_i.addr < `MBAC_PRAM_LO |=> violation_o;
  endproperty
  a_boot_aram: assert property (p_boot_aram) else $error("boot mode reached app ram");
  property p_seg_local;
    (sfr_wr_i || sfr_rd_i) && sfr_addr_i[7:4] == `MBAC_GRP_SEG |-> !ext_wr_o && !ext_rd_o;
  endproperty
  a_seg_local: assert property (p_seg_local) else $error("segment register went outside");
  property p_cpu_grp;
    sfr_rd_i && sfr_addr_i[7:4] == `MBAC_GRP_CPU && cpu_mode_i <= `MBAC_MODE_USER
      |-> ext_rd_o && ext_addr_o == sfr_addr_i;
  endproperty
  a_cpu_grp: assert property (p_cpu_grp) else $error("cpu register read blocked");
  property p_user_seg_zero;
    sfr_rd_i && cpu_mode_i == `MBAC_MODE_USER && sfr_addr_i[7:4] == `MBAC_GRP_SEG
      |=> sfr_rdata_o == 8'h00;
  endproperty
  a_user_seg_zero: assert property (p_user_seg_zero) else $error("denied read not zero");
  property p_pkc_wr_eep;
    pkc_valid_i && pkc_ready_o && pkc_write_i && pkc_addr_i >= `MBAC_OEEP_LO
      && pkc_addr_i < `MBAC_ORAM_LO |=> pkc_denied_o && !mem_cmd_o.we;
  endproperty
  a_pkc_wr_eep: assert property (p_pkc_wr_eep) else $error("coprocessor wrote eeprom");
  property p_ext_wr_cause;
    ext_wr_o |-> sfr_wr_i && sfr_addr_i[7:4] != `MBAC_GRP_SEG && sfr_addr_i[7:4] != `MBAC_GRP_FW;
  endproperty
  a_ext_wr_cause: assert property (p_ext_wr_cause) else $error("stray outside write");
endmodule
bind mbac_top mbac_chk u_chk (.clock_i, .rst_n_i, .cpu_mode_i, .cpu_req_i, .mem_cmd_o,
  .violation_o, .pkc_valid_i, .pkc_write_i, .pkc_addr_i, .pkc_ready_o, .pkc_denied_o,
  .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .ext_addr_o, .ext_wr_o, .ext_rd_o);

// ===== test/mbac_ext_regs.sv
// Behavioural bank of the registers that sit outside the access control unit.
module mbac_ext_regs (
  // Clock.
  input wire logic clock_i,
  // Gated register strobes from the unit.
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs_q [256];
  // Non-zero start so that a denied read returning zero is told apart.
  initial begin
    foreach (regs_q[i]) regs_q[i] = 8'hEE;
    rdata_o = 8'h00;
  end
  // Store writes; data stands only after a read, otherwise it toggles each cycle.
  always @(posedge clock_i) begin
    if (wr_i) regs_q[addr_i] <= wdata_i;
    if (rd_i) rdata_o <= regs_q[addr_i];
    else rdata_o <= ~rdata_o;
  end
endmodule

// ===== test/tb.sv
// Self-checking bench of the mode based access control unit.
`include "mbac_defs.svh"
module tb
  import mbac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] BT = `MBAC_MODE_BOOT, TS = `MBAC_MODE_TEST, OS = `MBAC_MODE_OS;
  localparam logic [2:0] SY = `MBAC_MODE_SYS, US = `MBAC_MODE_USER;
  localparam mbac_op_e RD = MBAC_OP_READ, WR = MBAC_OP_WRITE, EX = MBAC_OP_EXEC;
  logic clock_i = 1'b0, rst_n = 1'b0, viol, pkr, pkden, swr = 1'b0, srd = 1'b0;
  logic pkv = 1'b0, pkw = 1'b0, ewr, erd;
  logic [2:0] mode = 3'h0, md;
  logic [15:0] pka = 16'h0000, rel = 16'h0000;
  logic [7:0] sa = 8'h00, sd = 8'h00, srdata, ea, ed, erdata;
  mbac_req_s req = '0;
  mbac_mem_s mc;
  int checked = 0, n_mismatch = 0, cyc = 0;
  always #25 clock_i = ~clock_i;
  mbac_top #(.SEGS(64)) dut (.clock_i(clock_i), .rst_n_i(rst_n), .cpu_mode_i(mode),
    .cpu_req_i(req), .mem_cmd_o(mc), .violation_o(viol), .pkc_valid_i(pkv),
    .pkc_write_i(pkw), .pkc_addr_i(pka), .pkc_wdata_i(8'hA5), .pkc_ready_o(pkr),
    .pkc_denied_o(pkden), .sfr_addr_i(sa), .sfr_wdata_i(sd), .sfr_wr_i(swr), .sfr_rd_i(srd),
    .sfr_rdata_o(srdata), .ext_addr_o(ea), .ext_wdata_o(ed), .ext_wr_o(ewr), .ext_rd_o(erd),
    .ext_rdata_i(erdata));
  mbac_ext_regs u_ext (.clock_i(clock_i), .addr_i(ea), .wdata_i(ed), .wr_i(ewr), .rd_i(erd),
    .rdata_o(erdata));
  // -----------------------------------------------------------------
  // Access tasks.
  // -----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic sm(input logic [2:0] x);
    @(posedge clock_i);
    mode <= x;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    sa <= a;
    sd <= d;
    swr <= 1'b1;
    @(posedge clock_i);
    swr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look just past that edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    sa <= a;
    srd <= 1'b1;
    @(posedge clock_i);
    srd <= 1'b0;
    #1;
    chk("sfr_rdata", {8'h00, srdata}, {8'h00, e});
  endtask
  // Expected physical address is the virtual one plus the relocation set in rel.
  task automatic m(input logic [2:0] x, input mbac_op_e op, input logic [15:0] a, input logic ok);
    @(posedge clock_i);
    mode <= x;
    req <= '{1'b1, op, a, 8'h3C};
    #1;
    chk("pkc_ready", {15'h0, pkr}, 16'h0000);
    @(posedge clock_i);
    req.valid <= 1'b0;
    #1;
    chk("violation", {15'h0, viol}, {15'h0, ~ok});
    chk("mem_en", {15'h0, mc.en}, {15'h0, ok});
    chk("mem_we", {15'h0, mc.we}, {15'h0, ok & (op == WR)});
    if (ok) chk("mem_addr", mc.addr, a + rel);
    if (ok) chk("mem_wdata", {8'h00, mc.wdata}, 16'h003C);
  endtask
  task automatic p(input logic w, input logic [15:0] a, input logic ok);
    @(posedge clock_i);
    pkv <= 1'b1;
    pkw <= w;
    pka <= a;
    #1;
    chk("pkc_ready", {15'h0, pkr}, 16'h0001);
    @(posedge clock_i);
    pkv <= 1'b0;
    #1;
    chk("pkc_denied", {15'h0, pkden}, {15'h0, ~ok});
    chk("mem_en", {15'h0, mc.en}, {15'h0, ok});
    if (ok) chk("mem_addr", mc.addr, a);
  endtask
  task automatic seg(input logic [7:0] i, r, input logic [15:0] f, l, o, h);
    wr(`MBAC_SEG_IDX, i);
    wr(`MBAC_SEG_RIGHTS, r);
    wr(8'h92, f[7:0]);
    wr(8'h93, f[15:8]);
    wr(8'h94, l[7:0]);
    wr(8'h95, l[15:8]);
    wr(8'h96, o[7:0]);
    wr(8'h97, o[15:8]);
    wr(8'h98, h[7:0]);
    wr(8'h99, h[15:8]);
    wr(`MBAC_SEG_COMMIT, 8'h00);
  endtask
  // A hang is cut short and counted as a mismatch.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // -----------------------------------------------------------------
  // Main sequence.
  // -----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock_i);
    rst_n <= 1'b1;
    sm(SY);
    for (int i = 0; i < 10; i++) rd(8'h90 + 8'(i), 8'h00);
    for (int i = 0; i < 6; i++) rd(8'hB0 + 8'(i), 8'h00);
    for (int k = 0; k < 2; k++) begin
      md = k ? OS : BT;
      m(md, RD, 16'h0800, 1);
      m(md, EX, 16'h0800, 1);
      m(md, WR, 16'h0800, 0);
      m(md, EX, 16'h4010, 1);
      m(md, WR, 16'hC010, 1);
      m(md, EX, 16'hC010, 0);
      m(md, RD, 16'h1000, 0);
      m(md, RD, 16'hC800, 0);
      m(md, RD, 16'hBFC0, 1);
    end
    m(TS, RD, 16'h0800, 1);
    m(TS, EX, 16'h3000, 1);
    m(TS, WR, 16'h9000, 1);
    m(TS, WR, 16'hF000, 1);
    m(TS, WR, 16'h2000, 0);
    m(OS, RD, 16'h3FC0, 1);
    m(OS, RD, 16'h3FBF, 0);
    m(OS, WR, 16'hBFC0, 0);
    m(SY, RD, 16'h1000, 1);
    m(SY, WR, 16'h5000, 1);
    m(SY, WR, 16'hEFFF, 1);
    m(SY, EX, 16'hC800, 0);
    m(SY, RD, 16'h4000, 0);
    m(SY, RD, 16'h0800, 0);
    m(3'h5, RD, 16'h1000, 0);
    sm(SY);
    wr(8'hB3, 8'hC9);
    wr(8'hB4, 8'h10);
    m(OS, WR, 16'hC900, 1);
    m(OS, RD, 16'hC90F, 1);
    m(OS, WR, 16'hC910, 0);
    m(OS, RD, 16'hC8FF, 0);
    sm(SY);
    wr(8'hE2, 8'hA5);
    wr(8'h80, 8'h3C);
    wr(8'hA0, 8'h96);
    sm(OS);
    wr(8'hC0, 8'h5A);
    rd(8'hC0, 8'h5A);
    rd(8'hE2, 8'h00);
    rd(8'hB3, 8'hC9);
    wr(8'hB0, 8'hFF);
    sm(SY);
    rd(8'hB0, 8'h00);
    rd(8'hC0, 8'h00);
    wr(8'hB0, 8'h02);
    sm(OS);
    rd(8'hE2, 8'hA5);
    sm(BT);
    wr(8'hD0, 8'h77);
    sm(TS);
    rd(8'hD0, 8'h77);
    sm(SY);
    rd(8'hD0, 8'h00);
    m(US, RD, 16'h2010, 0);
    rd(8'hE2, 8'h00);
    sm(SY);
    seg(8'd0, 8'h05, 16'h2000, 16'h20FF, 16'h1000, 16'h0002);
    rd(`MBAC_SEG_RIGHTS, 8'h05);
    seg(8'd1, 8'h00, 16'h2100, 16'h21FF, 16'h0000, 16'hFFFF);
    seg(8'd63, 8'h06, 16'h5000, 16'h50FF, 16'h0000, 16'h0000);
    rel = 16'h1000;
    m(US, RD, 16'h2010, 1);
    m(US, EX, 16'h2000, 1);
    m(US, WR, 16'h2010, 0);
    rel = 16'h0000;
    m(US, RD, 16'h2100, 0);
    m(US, WR, 16'h5000, 1);
    m(US, EX, 16'h5000, 0);
    rd(8'hE2, 8'hA5);
    wr(8'hE2, 8'h11);
    rd(8'hE2, 8'h11);
    rd(8'hE4, 8'h00);
    rd(8'h80, 8'h3C);
    rd(8'hA0, 8'h96);
    rd(8'hA1, 8'h00);
    rd(8'h90, 8'h00);
    wr(8'h90, 8'h07);
    sm(SY);
    rd(8'h90, 8'h3F);
    sm(BT);
    rd(8'h90, 8'h00);
    p(1'b1, 16'hF000, 1);
    p(1'b0, 16'h4000, 1);
    p(1'b0, 16'hBFFF, 1);
    p(1'b1, 16'h4000, 0);
    p(1'b0, 16'h1000, 0);
    p(1'b1, 16'hC800, 0);
    end_of_test();
  end
endmodule
